// ==== core/rpc_reset_pin_controller.sv ====
// What this block does
// R1: Power reset pin low holds device reset
// R2: Power reset release gives full POR, then run
// R3: Soft reset pin low keeps core reset
// R4: Soft reset release resets core, registers, peripherals
// R5: Soft reset spares POR, RTC, debug state
// R6: Sensed low pin driven low six cycles
// R7: Release, resample, repeat until pin high
// R8: Synchronise soft reset pin before use
`timescale 1ns/1ns
module rpc_reset_pin_controller
    import rpc_pkg::*;
(
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic hwPowerResetInN,   // Power reset pin, active low
    input  wire logic softResetIoNIn,    // Soft reset pin level
    output logic      softResetIoNOut,   // Soft reset pin drive value
    output logic      softResetIoNOe,    // Soft reset pin drive enable
    output rpc_rst_s  rstOut             // Domain resets
);
    // ==========================================================
    // Declarations
    // ==========================================================
    logic       pinSync;       // Synchronised soft pin
    rpc_state_e state_r;       // Sequencer state
    rpc_state_e state_nxt;     // Next state
    logic [3:0] driveCnt_r;    // Drive-low counter
    logic [3:0] porCnt_r;      // Power-on stretch counter
    logic       porDone_r;     // POR stretch complete
    logic       oe_r;          // Drive enable register
    logic       coreRstN_r;    // Core reset register
    logic       porRstN_r;     // POR register

    // ==========================================================
    // Counter helpers
    // ==========================================================
    // True when a 4-bit count has reached its last value
    function automatic logic cnt_hit(input logic [3:0] cnt, input logic [3:0] last);
        return (cnt == last);
    endfunction : cnt_hit

    // Next value of a 4-bit up-counter, carry dropped on purpose
    function automatic logic [3:0] cnt_step(input logic [3:0] cnt);
        return cnt + 4'h1;
    endfunction : cnt_step

    // ==========================================================
    // Pin synchroniser
    // ==========================================================
    rpc_sync u_sync (                                                // R8
        .mclk (mclk),
        .nrst (nrst),
        .din  (softResetIoNIn),
        .dout (pinSync)
    );

    // ==========================================================
    // Power reset handling
    // ==========================================================
    // Hold POR while pin low, stretch a few cycles after release
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            porCnt_r  <= DRIVE_CNT_RST;
            porDone_r <= 1'b0;
            porRstN_r <= 1'b0;
        end else if (!hwPowerResetInN) begin                         // R1
            // Pin low wins over a finishing stretch
            porCnt_r  <= DRIVE_CNT_RST;
            porDone_r <= 1'b0;
            porRstN_r <= 1'b0;
        end else if (!porDone_r) begin                               // R2
            if (cnt_hit(porCnt_r, POR_CNT_LAST)) begin
                porDone_r <= 1'b1;
                porRstN_r <= 1'b1;
            end else begin
                porCnt_r <= cnt_step(porCnt_r);
            end
        end
    end

    // ==========================================================
    // Soft reset sequencer
    // ==========================================================
    // Next state: sense low, drive, release, resample
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            RPC_IDLE: begin
                if (!pinSync) begin                                  // R6
                    state_nxt = RPC_DRIVE;
                end
            end
            RPC_DRIVE: begin
                if (cnt_hit(driveCnt_r, DRIVE_CNT_LAST)) begin       // R7
                    state_nxt = RPC_SENSE;
                end
            end
            RPC_SENSE: begin
                // Wait for released pin to pass synchroniser
                // before the level is trusted again
                if (cnt_hit(driveCnt_r, DRIVE_CNT_LAST)) begin
                    state_nxt = pinSync ? RPC_IDLE : RPC_DRIVE;      // R7
                end
            end
            default: begin
                state_nxt = RPC_IDLE;
            end
        endcase
    end

    // State register, held idle during POR
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r <= RPC_IDLE;
        end else if (!porRstN_r) begin
            state_r <= RPC_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Counter for drive interval and sense settle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            driveCnt_r <= DRIVE_CNT_RST;
        end else if (state_nxt != state_r || state_r == RPC_IDLE) begin
            driveCnt_r <= DRIVE_CNT_RST;
        end else if (state_r == RPC_DRIVE) begin
            driveCnt_r <= cnt_step(driveCnt_r);                      // R6
        end else if (!cnt_hit(driveCnt_r, DRIVE_CNT_LAST)) begin
            // Sense count parks at its last value until the state moves
            driveCnt_r <= cnt_step(driveCnt_r);
        end
    end

    // Pin drive: enable registered from next state, so high in cycles whose state is drive, except after an edge that saw the power pin low
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            oe_r <= 1'b0;
        end else begin
            // Power pin low stops the drive at once
            oe_r <= hwPowerResetInN && porRstN_r && (state_nxt == RPC_DRIVE); // R1 R6
        end
    end

    // Core reset low while sequence active or POR
    // Power pin low drops it on the same edge as POR, so no extra run cycle
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            coreRstN_r <= 1'b0;
        end else begin
            coreRstN_r <= hwPowerResetInN && porRstN_r && (state_nxt == RPC_IDLE); // R1 R3 R4
        end
    end

    // ==========================================================
    // Outputs, registered except the constant drive value
    // ==========================================================
    assign softResetIoNOut  = 1'b0;   // Constant low drive, only enable toggles
    assign softResetIoNOe   = oe_r;
    // POR rail not touched by soft reset
    assign rstOut.porRstN   = porRstN_r;                             // R5
    assign rstOut.coreRstN  = coreRstN_r;
    assign rstOut.runEn     = coreRstN_r;

    // ==========================================================
    // Checks
    // ==========================================================
    chk_por_hold: assert property (@(posedge mclk) disable iff (!nrst) // R1
        !hwPowerResetInN |=> !rstOut.porRstN && !rstOut.runEn)
        else $error("POR not held while power pin low");

    chk_por_release: assert property (@(posedge mclk) disable iff (!nrst) // R2
        $rose(hwPowerResetInN) |-> ##[1:6] rstOut.porRstN)
        else $error("POR not released after power pin high");

    chk_soft_hold: assert property (@(posedge mclk) disable iff (!nrst) // R3
        (state_r != RPC_IDLE) |-> !rstOut.coreRstN)
        else $error("Core not held in soft reset");

    chk_core_release: assert property (@(posedge mclk) disable iff (!nrst) // R4
        (hwPowerResetInN && porRstN_r && state_r == RPC_SENSE && state_nxt == RPC_IDLE) |=> rstOut.coreRstN)
        else $error("Core not released after pin high");

    chk_por_spared: assert property (@(posedge mclk) disable iff (!nrst) // R5
        (rstOut.porRstN && hwPowerResetInN && state_r != RPC_IDLE) |=> rstOut.porRstN)
        else $error("Soft reset disturbed POR");

    chk_drive_len: assert property (@(posedge mclk) disable iff (!nrst) // R6
        (hwPowerResetInN && $rose(softResetIoNOe)) |-> softResetIoNOe[*6] ##1 !softResetIoNOe)
        else $error("Drive low not six cycles");

    chk_resample: assert property (@(posedge mclk) disable iff (!nrst) // R7
        (state_r == RPC_SENSE) |-> !softResetIoNOe)
        else $error("Pin driven during sense");

    // Sequencer may only act on the pin level seen two edges back
    chk_sync_gate: assert property (@(posedge mclk) disable iff (!nrst) // R8
        (state_r == RPC_IDLE && porRstN_r && $past(softResetIoNIn, 2))
        |=> state_r == RPC_IDLE)
        else $error("Sequencer left idle without synced low");

    cov_soft_cycle: cover property (@(posedge mclk) disable iff (!nrst)
        state_r == RPC_SENSE ##1 state_r == RPC_IDLE);
    cov_repeat: cover property (@(posedge mclk) disable iff (!nrst)
        state_r == RPC_SENSE ##1 state_r == RPC_DRIVE);
    cov_por: cover property (@(posedge mclk) disable iff (!nrst)
        $rose(rstOut.porRstN));

    chk_core_por: assert property (@(posedge mclk) disable iff (!nrst) // R1
        !rstOut.porRstN |-> !rstOut.coreRstN && !rstOut.runEn)
        else $error("Core running while POR active");

    chk_drive_gap: assert property (@(posedge mclk) disable iff (!nrst) // R7
        (porRstN_r && $fell(softResetIoNOe)) |-> !softResetIoNOe[*6])
        else $error("Pin not released for a full sense window");

    chk_power_drop: assert property (@(posedge mclk) disable iff (!nrst) // R1
        !hwPowerResetInN |=> !softResetIoNOe)
        else $error("Soft pin driven during power reset");

    // Drive burst start and power cut while running
    cov_drive_start: cover property (@(posedge mclk) disable iff (!nrst)
        $rose(softResetIoNOe));
    cov_power_cut: cover property (@(posedge mclk) disable iff (!nrst)
        $fell(rstOut.porRstN));
endmodule : rpc_reset_pin_controller

// ==== core/rpc_pkg.sv ====
package rpc_pkg;
    // ==========================================================
    // Timing constants
    // ==========================================================
    localparam int          CLK_PERIOD_NS    = 10;        // System clock period
    localparam int          DRIVE_LOW_CYCLES = 6;         // Drive-low interval in system clocks
    localparam logic [3:0]  DRIVE_CNT_LAST   = 4'(DRIVE_LOW_CYCLES - 1); // Last count value
    localparam logic [3:0]  DRIVE_CNT_RST    = 4'h0;      // Counter value after reset
    localparam int          POR_HOLD_CYCLES  = 4;         // Stretch of power-on reset after release
    localparam logic [3:0]  POR_CNT_LAST     = 4'(POR_HOLD_CYCLES - 1);
    localparam logic [1:0]  SYNC_RST         = 2'h3;      // Synchroniser idles at pin high

    // ==========================================================
    // Soft reset pin sequencer states (Gray along sense-drive loop)
    // ==========================================================
    typedef enum logic [1:0] {
        RPC_IDLE  = 2'b00,  // Pin high, core running
        RPC_DRIVE = 2'b01,  // Driving pin low
        RPC_SENSE = 2'b11   // Pin released, settling and sampling
    } rpc_state_e;

    // ==========================================================
    // Reset outputs toward the chip domains
    // ==========================================================
    typedef struct packed {
        logic porRstN;   // Whole chip except RTC, active low
        logic coreRstN;  // CPU, registers and peripherals, active low
        logic runEn;     // Execution allowed
    } rpc_rst_s;
endpackage : rpc_pkg

// ==== core/rpc_sync.sv ====
`timescale 1ns/1ns
// ==========================================================
// Two-stage level synchroniser
// ==========================================================
module rpc_sync
    import rpc_pkg::*;
(
    input  wire logic mclk,
    input  wire logic nrst,
    input  wire logic din,
    output logic      dout
);
    logic [1:0] stage_r;  // Stage 0 read only by stage 1

    // Shift chain, idles high
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stage_r <= SYNC_RST;
        end else begin
            stage_r <= {stage_r[0], din};
        end
    end

    assign dout = stage_r[1];
endmodule : rpc_sync

// ==== test/rpc_reset_source.sv ====
`timescale 1ns/1ns
// ==========================================================
// External reset source and soft reset pin wire
// ==========================================================
module rpc_reset_source (
    input  wire logic       mclk,
    input  wire logic       holdReq,  // Starts an external low pulse
    input  wire logic [7:0] holdLen,  // Pulse length in cycles
    input  wire logic       devOe,    // Device drive enable
    input  wire logic       devOut,   // Device drive value
    output logic            pinLevel, // Resolved pin level
    output logic            extLow    // External source pulls low
);
    logic [7:0] holdCnt = 8'h00;      // Cycles of low pulse left
    // Counts down the external low pulse
    always_ff @(posedge mclk) begin
        if (holdReq) begin
            holdCnt <= holdLen;
        end else if (holdCnt != 8'h00) begin
            holdCnt <= holdCnt - 8'h01;
        end
    end
    assign extLow   = (holdCnt != 8'h00);
    // Pull-up wins only while nobody drives low
    assign pinLevel = ~((devOe & ~devOut) | extLow);
endmodule : rpc_reset_source

// ==== test/tb_reset_pin_controller.sv ====
`timescale 1ns/1ns
module tb_reset_pin_controller import rpc_pkg::*;;
    logic       mclk, nrst, hwPowerResetInN, holdReq, pinLevel, extLow, oe, pinOut;
    logic [7:0] holdLen;
    rpc_rst_s   rstOut;
    int         errors = 0, samplesChecked = 0, cycles = 0, run = 0, bursts = 0, k, len, n;
    int         seed;
    rpc_reset_pin_controller u_dut (.mclk(mclk), .nrst(nrst), .hwPowerResetInN(hwPowerResetInN),
        .softResetIoNIn(pinLevel), .softResetIoNOut(pinOut), .softResetIoNOe(oe), .rstOut(rstOut));
    rpc_reset_source u_src (.mclk(mclk), .holdReq(holdReq), .holdLen(holdLen), .devOe(oe),
        .devOut(pinOut), .pinLevel(pinLevel), .extLow(extLow));
    // ==========================================================
    // Clock
    // ==========================================================
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // Compares and reports one value
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Prints counts and verdict
    task automatic finish_test();
        $display("mismatches=%0d comparisons=%0d", errors, samplesChecked);
        if (errors == 0 && samplesChecked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    // Waits a bounded time for the core to leave reset
    task automatic wait_core(input int lim);
        int i;
        for (i = 0; i < lim && rstOut.coreRstN !== 1'b1; i++) @(negedge mclk);
    endtask : wait_core
    // Fewest drive bursts a pulse of this length must cause
    function automatic int exp_min(input int l);
        return (l / 12 < 1) ? 1 : l / 12;
    endfunction : exp_min
    // ==========================================================
    // Monitor: drive burst length, core held, timeout
    // ==========================================================
    always @(negedge mclk) begin
        cycles++;
        if (cycles > 20000) begin
            errors++;
            finish_test();
        end
        if (oe === 1'b1) begin
            run++;
            check(rstOut.coreRstN, 1'b0);
            check(rstOut.porRstN, 1'b1);
            check(pinOut, 1'b0);
        end else if (run != 0) begin
            check(8'(run), 8'(DRIVE_LOW_CYCLES));
            bursts++;
            run = 0;
        end
    end
    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        seed = 32'hf71b56f9;
        nrst = 1'b0;
        hwPowerResetInN = 1'b1;
        holdReq = 1'b0;
        holdLen = 8'h00;
        repeat (8) @(negedge mclk);
        nrst = 1'b1;
        wait_core(20);
        check(rstOut, 8'h07);
        // Power pin low, soft pin pulled meanwhile
        hwPowerResetInN = 1'b0;
        repeat (3) @(negedge mclk);
        check(rstOut, 8'h00);
        holdReq = 1'b1;
        holdLen = 8'h14;
        @(negedge mclk);
        holdReq = 1'b0;
        repeat (10) @(negedge mclk);
        check(oe, 1'b0);
        repeat (15) @(negedge mclk);
        hwPowerResetInN = 1'b1;
        for (n = 0; n < 20 && rstOut.porRstN !== 1'b1; n++) @(negedge mclk);
        check(n >= POR_HOLD_CYCLES && n <= POR_HOLD_CYCLES + 2, 1'b1);
        @(negedge mclk);
        check(rstOut, 8'h07);
        // Soft pin pulses: short, one loop, then random
        for (k = 0; k < 10; k++) begin
            len = (k == 0) ? 1 : (k == 1) ? 12 : 1 + ($unsigned($random(seed)) % 40);
            bursts = 0;
            holdReq = 1'b1;
            holdLen = len[7:0];
            @(negedge mclk);
            holdReq = 1'b0;
            check(oe, 1'b0);
            repeat (4) @(negedge mclk);
            check(rstOut.coreRstN, 1'b0);
            wait_core(len + 60);
            check(rstOut, 8'h07);
            check(extLow, 1'b0);
            check(bursts >= exp_min(len) && bursts <= exp_min(len) + 2, 1'b1);
            repeat (3) @(negedge mclk);
        end
        finish_test();
    end
endmodule : tb_reset_pin_controller
